// File: bsi_cell.sv
// one boundary-scan cell: capture/shift stage plus update latch
`timescale 1ns/100ps
`default_nettype none
module bsi_cell (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic capture,
	input wire logic shift,
	input wire logic update,
	input wire logic pinValue,
	input wire logic serialIn,
	output logic stage,
	output logic held
);
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			stage <= 1'b0;
		end else if (capture) begin
			stage <= pinValue;
		end else if (shift) begin
			stage <= serialIn;
		end
	end
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			held <= 1'b0;
		end else if (update) begin
			held <= stage;
		end
	end
endmodule : bsi_cell
`default_nettype wire

// File: bsi_pkg.sv
// constants and types for the boundary-scan instruction logic
// Summary of operation
// - clamp selects bypass, resets core, drives preloads
// - clamp activates on falling tck in update-ir
// - bypass code gives one-bit tdi-tdo path
// - bypass stage captures zero in capture-dr
// - bypass activates on falling tck in update-ir
// - code one selects 32-bit identification register
// - id holds revision, design center, device number
// - id bits 11..1 maker code, bit0 one
// - boundary register in path for extest, sample only
// - cells capture inputs, force outputs, set direction
// - all six standard instructions are implemented
// - three-bit ir, msb nearest tdi, update on fall
// - tap reset loads identification instruction
// - extest drives, sample captures/preloads, highz floats
package bsi_pkg;
	localparam int IR_W = 3;
	localparam int ID_W = 32;
	localparam logic [2:0] OP_EXTEST = 3'h0;
	localparam logic [2:0] OP_IDENTIFICATION_WORD = 3'h1;
	localparam logic [2:0] OP_SAMPLE = 3'h4;
	localparam logic [2:0] OP_HIGHZ = 3'h5;
	localparam logic [2:0] OP_CLAMP = 3'h6;
	localparam logic [2:0] OP_BYPASS = 3'h7;
	localparam logic [2:0] IR_CAPTURE = 3'h1;
	localparam int ID_REV_LSB = 28;
	localparam int ID_DC_LSB = 22;
	localparam int ID_DEV_LSB = 12;
	localparam int ID_MFR_LSB = 1;
	localparam logic BYP_CAPTURE = 1'b0;
	localparam logic ID_MARK = 1'b1;
	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
	} bsi_tap_t;
	typedef enum logic [1:0] {PATH_BSR, PATH_ID, PATH_BYP} bsi_path_t;
endpackage : bsi_pkg

// File: bsi_tap.sv
// boundary-scan tap, instruction decode, id, bypass and boundary chain
`timescale 1ns/100ps
`default_nettype none
module bsi_tap #(
	parameter int NPINS = 4,
	parameter logic [3:0] ID_REV = 4'h0, // arbitrary value
	parameter logic [5:0] ID_DC = 6'h00, // arbitrary value
	parameter logic [9:0] ID_DEV = 10'h000, // arbitrary value
	parameter logic [10:0] ID_MFR = 11'h000 // arbitrary value
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic trst_n,
	output logic tdo,
	output logic tdoEn_n,
	input wire logic [NPINS-1:0] pinIn,
	input wire logic [NPINS-1:0] coreOut,
	input wire logic [NPINS-1:0] coreOutEn_n,
	output logic [NPINS-1:0] pinOut,
	output logic [NPINS-1:0] pinOutEn_n,
	output logic coreReset_n,
	output logic [2:0] activeInstr
);
	// sync tck/tms/tdi/trst_n: two flops each before use
	logic [3:0] sync1_r;
	logic [3:0] sync2_r;
	logic tckLast_r;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_r <= 4'h0;
			sync2_r <= 4'h0;
			tckLast_r <= 1'b0;
		end else begin
			sync1_r <= {trst_n, tdi, tms, tck};
			sync2_r <= sync1_r;
			tckLast_r <= sync2_r[0];
		end
	end
	wire tckS = sync2_r[0];
	wire tmsS = sync2_r[1];
	wire tdiS = sync2_r[2];
	wire trstS_n = sync2_r[3];
	wire tckRise = tckS & ~tckLast_r;
	wire tckFall = ~tckS & tckLast_r;

	// pads are asynchronous to ref_clk: two flops before the cells capture them
	logic [NPINS-1:0] pinSync1_r;
	logic [NPINS-1:0] pinSync2_r;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pinSync1_r <= '0;
			pinSync2_r <= '0;
		end else begin
			pinSync1_r <= pinIn;
			pinSync2_r <= pinSync1_r;
		end
	end

	// tap state machine, advanced on rising tck
	bsi_pkg::bsi_tap_t state_r;
	bsi_pkg::bsi_tap_t state_nxt;
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			bsi_pkg::TAP_RESET: state_nxt = tmsS ? bsi_pkg::TAP_RESET : bsi_pkg::TAP_IDLE;
			bsi_pkg::TAP_IDLE: state_nxt = tmsS ? bsi_pkg::SEL_DR : bsi_pkg::TAP_IDLE;
			bsi_pkg::SEL_DR: state_nxt = tmsS ? bsi_pkg::SEL_IR : bsi_pkg::CAP_DR;
			bsi_pkg::CAP_DR: state_nxt = tmsS ? bsi_pkg::EX1_DR : bsi_pkg::SH_DR;
			bsi_pkg::SH_DR: state_nxt = tmsS ? bsi_pkg::EX1_DR : bsi_pkg::SH_DR;
			bsi_pkg::EX1_DR: state_nxt = tmsS ? bsi_pkg::UPD_DR : bsi_pkg::PAU_DR;
			bsi_pkg::PAU_DR: state_nxt = tmsS ? bsi_pkg::EX2_DR : bsi_pkg::PAU_DR;
			bsi_pkg::EX2_DR: state_nxt = tmsS ? bsi_pkg::UPD_DR : bsi_pkg::SH_DR;
			bsi_pkg::UPD_DR: state_nxt = tmsS ? bsi_pkg::SEL_DR : bsi_pkg::TAP_IDLE;
			bsi_pkg::SEL_IR: state_nxt = tmsS ? bsi_pkg::TAP_RESET : bsi_pkg::CAP_IR;
			bsi_pkg::CAP_IR: state_nxt = tmsS ? bsi_pkg::EX1_IR : bsi_pkg::SH_IR;
			bsi_pkg::SH_IR: state_nxt = tmsS ? bsi_pkg::EX1_IR : bsi_pkg::SH_IR;
			bsi_pkg::EX1_IR: state_nxt = tmsS ? bsi_pkg::UPD_IR : bsi_pkg::PAU_IR;
			bsi_pkg::PAU_IR: state_nxt = tmsS ? bsi_pkg::EX2_IR : bsi_pkg::PAU_IR;
			bsi_pkg::EX2_IR: state_nxt = tmsS ? bsi_pkg::UPD_IR : bsi_pkg::SH_IR;
			bsi_pkg::UPD_IR: state_nxt = tmsS ? bsi_pkg::SEL_DR : bsi_pkg::TAP_IDLE;
			default: state_nxt = bsi_pkg::TAP_RESET;
		endcase
	end
	// trst_n handled synchronously after sync, so the async reset sees only constants
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= bsi_pkg::TAP_RESET;
		end else if (!trstS_n) begin
			state_r <= bsi_pkg::TAP_RESET;
		end else if (tckRise) begin
			state_r <= state_nxt;
		end
	end

	// instruction register: shift stage and hold stage
	logic [2:0] irShift_r;
	logic [2:0] irHold_r;
	wire inReset = (state_r == bsi_pkg::TAP_RESET);
	wire irCap = tckRise & (state_r == bsi_pkg::CAP_IR);
	wire irSh = tckRise & (state_r == bsi_pkg::SH_IR);
	wire irUpd = tckFall & (state_r == bsi_pkg::UPD_IR);
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			irShift_r <= bsi_pkg::IR_CAPTURE;
		end else if (irCap) begin
			irShift_r <= bsi_pkg::IR_CAPTURE;
		end else if (irSh) begin
			irShift_r <= {tdiS, irShift_r[2:1]};
		end
	end
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			irHold_r <= bsi_pkg::OP_IDENTIFICATION_WORD;
		end else if (inReset) begin
			irHold_r <= bsi_pkg::OP_IDENTIFICATION_WORD;
		end else if (irUpd) begin
			irHold_r <= irShift_r;
		end
	end

	// decode: every code maps to a defined path
	wire isExtest = (irHold_r == bsi_pkg::OP_EXTEST);
	wire isSample = (irHold_r == bsi_pkg::OP_SAMPLE);
	wire isIdcode = (irHold_r == bsi_pkg::OP_IDENTIFICATION_WORD);
	wire isHighz = (irHold_r == bsi_pkg::OP_HIGHZ);
	wire isClamp = (irHold_r == bsi_pkg::OP_CLAMP);
	bsi_pkg::bsi_path_t path;
	assign path = (isExtest | isSample) ? bsi_pkg::PATH_BSR
		: isIdcode ? bsi_pkg::PATH_ID
		: bsi_pkg::PATH_BYP;

	// data register controls
	wire drCap = tckRise & (state_r == bsi_pkg::CAP_DR);
	wire drSh = tckRise & (state_r == bsi_pkg::SH_DR);
	wire drUpd = tckFall & (state_r == bsi_pkg::UPD_DR);

	// bypass stage
	logic byp_r;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			byp_r <= bsi_pkg::BYP_CAPTURE;
		end else if (drCap && path == bsi_pkg::PATH_BYP) begin
			byp_r <= bsi_pkg::BYP_CAPTURE;
		end else if (drSh && path == bsi_pkg::PATH_BYP) begin
			byp_r <= tdiS;
		end
	end

	// identification register
	wire [bsi_pkg::ID_W-1:0] idWord;
	assign idWord[bsi_pkg::ID_W-1:bsi_pkg::ID_REV_LSB] = ID_REV;
	assign idWord[bsi_pkg::ID_REV_LSB-1:bsi_pkg::ID_DC_LSB] = ID_DC;
	assign idWord[bsi_pkg::ID_DC_LSB-1:bsi_pkg::ID_DEV_LSB] = ID_DEV;
	assign idWord[bsi_pkg::ID_DEV_LSB-1:bsi_pkg::ID_MFR_LSB] = ID_MFR;
	assign idWord[bsi_pkg::ID_MFR_LSB-1] = bsi_pkg::ID_MARK;
	logic [bsi_pkg::ID_W-1:0] id_r;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			id_r <= '0;
		end else if (drCap && path == bsi_pkg::PATH_ID) begin
			id_r <= idWord;
		end else if (drSh && path == bsi_pkg::PATH_ID) begin
			id_r <= {tdiS, id_r[bsi_pkg::ID_W-1:1]};
		end
	end

	// boundary chain: per pin a data cell then an enable cell
	localparam int NCELL = 2 * NPINS;
	wire bsrCap = drCap & (path == bsi_pkg::PATH_BSR);
	wire bsrSh = drSh & (path == bsi_pkg::PATH_BSR);
	wire bsrUpd = drUpd & (isExtest | isSample);
	logic [NCELL:0] chain;
	logic [NCELL-1:0] upd;
	logic [NPINS-1:0] updData;
	logic [NPINS-1:0] updEn_n;
	assign chain[NCELL] = tdiS;
	genvar g;
	generate
		for (g = 0; g < NPINS; g++) begin : gCell
			bsi_cell uData (
				.ref_clk(ref_clk),
				.reset_n(reset_n),
				.capture(bsrCap),
				.shift(bsrSh),
				.update(bsrUpd),
				.pinValue(pinSync2_r[g]),
				.serialIn(chain[2*g+1]),
				.stage(chain[2*g]),
				.held(upd[2*g])
			);
			bsi_cell uEn (
				.ref_clk(ref_clk),
				.reset_n(reset_n),
				.capture(bsrCap),
				.shift(bsrSh),
				.update(bsrUpd),
				.pinValue(coreOutEn_n[g]),
				.serialIn(chain[2*g+2]),
				.stage(chain[2*g+1]),
				.held(upd[2*g+1])
			);
			assign updData[g] = upd[2*g];
			assign updEn_n[g] = upd[2*g+1];
		end
	endgenerate

	// pin drive selection
	wire forcePins = isExtest | isClamp;
	wire [NPINS-1:0] pinOut_nxt = forcePins ? updData : coreOut;
	wire [NPINS-1:0] pinEn_nxt = isHighz ? {NPINS{1'b1}}
		: forcePins ? updEn_n : coreOutEn_n;

	// tdo changes on falling tck while shifting
	wire tdoSel = (path == bsi_pkg::PATH_BSR) ? chain[0]
		: (path == bsi_pkg::PATH_ID) ? id_r[0] : byp_r;
	wire shiftSt = (state_r == bsi_pkg::SH_DR) | (state_r == bsi_pkg::SH_IR);
	wire tdoBit = (state_r == bsi_pkg::SH_IR) ? irShift_r[0] : tdoSel;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			tdo <= 1'b0;
			tdoEn_n <= 1'b1;
		end else if (tckFall) begin
			tdo <= tdoBit;
			tdoEn_n <= ~shiftSt;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pinOut <= '0;
			pinOutEn_n <= '1;
			coreReset_n <= 1'b1;
			activeInstr <= bsi_pkg::OP_IDENTIFICATION_WORD;
		end else begin
			pinOut <= pinOut_nxt;
			pinOutEn_n <= pinEn_nxt;
			coreReset_n <= ~isClamp;
			activeInstr <= irHold_r;
		end
	end
endmodule : bsi_tap
`default_nettype wire

// File: bsi_tap_properties.sv
// assertions on instruction, core reset and pin outputs
`timescale 1ns/100ps
`default_nettype none
module bsi_tap_properties #(
	parameter int NPINS = 4
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic trst_n,
	input wire logic tdoEn_n,
	input wire logic [NPINS-1:0] coreOut,
	input wire logic [NPINS-1:0] pinOut,
	input wire logic [NPINS-1:0] pinOutEn_n,
	input wire logic coreReset_n,
	input wire logic [2:0] activeInstr
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	property p_ir; $rose(reset_n) |-> activeInstr == bsi_pkg::OP_IDENTIFICATION_WORD; endproperty
	a_ir: assert property (p_ir) else $error("reset instr");
	// two sync flops, state, hold stage and output register: five edges after the first low sample
	property p_trst; (!trst_n)[*6] |-> activeInstr == bsi_pkg::OP_IDENTIFICATION_WORD; endproperty
	a_trst: assert property (p_trst) else $error("test reset instr");
	property p_cr; (activeInstr == bsi_pkg::OP_CLAMP)[*2] |-> !coreReset_n; endproperty
	a_cr: assert property (p_cr) else $error("no core reset");
	property p_run; (activeInstr != bsi_pkg::OP_CLAMP)[*2] |-> coreReset_n; endproperty
	a_run: assert property (p_run) else $error("stray core reset");
	property p_hz; (activeInstr == bsi_pkg::OP_HIGHZ)[*2] |-> &pinOutEn_n; endproperty
	a_hz: assert property (p_hz) else $error("pin driven");
	property p_hold; (activeInstr == bsi_pkg::OP_CLAMP)[*3] |-> $stable(pinOut) && $stable(pinOutEn_n); endproperty
	a_hold: assert property (p_hold) else $error("clamp moved");
	property p_byp; (activeInstr == bsi_pkg::OP_BYPASS)[*3] |-> pinOut == $past(coreOut); endproperty
	a_byp: assert property (p_byp) else $error("bypass pins");
	property p_smp; (activeInstr == bsi_pkg::OP_SAMPLE)[*3] |-> pinOut == $past(coreOut); endproperty
	a_smp: assert property (p_smp) else $error("sample pins");
	property p_upd; $changed(activeInstr) |-> $past(tdoEn_n); endproperty
	a_upd: assert property (p_upd) else $error("instr in shift");
	cover property (activeInstr == bsi_pkg::OP_CLAMP);
	cover property (!tdoEn_n);
	cover property ($fell(coreReset_n));
endmodule : bsi_tap_properties
bind bsi_tap bsi_tap_properties #(.NPINS(NPINS)) u_props (.*);
`default_nettype wire

// File: bsi_tap_tb_top.sv
// bench: tester drives the scan port, a model predicts scan data and pins
`timescale 1ns/100ps
`default_nettype none
module bsi_tap_tb_top;
	localparam int NPINS = 4;
	// identification fields: arbitrary values, non-zero so a misplaced field shows
	localparam logic [3:0] ID_REV = 4'hA;
	localparam logic [5:0] ID_DC = 6'h2B;
	localparam logic [9:0] ID_DEV = 10'h35C;
	localparam logic [10:0] ID_MFR = 11'h4E7;
	logic ref_clk, reset_n, trst_n, tck, tms, tdi, tdo, tdoEn_n, coreReset_n, q, hz;
	logic [NPINS-1:0] pinIn, coreOut, coreOutEn_n, pinOut, pinOutEn_n, ep, ee;
	logic [2:0] activeInstr, code;
	logic [31:0] din, dout;
	logic [2*NPINS-1:0] upd = '0;
	logic [2*NPINS-1:0] cap;
	int n_errors = 0;
	int total_checks = 0;
	bsi_tap #(
		.NPINS(NPINS),
		.ID_REV(ID_REV),
		.ID_DC(ID_DC),
		.ID_DEV(ID_DEV),
		.ID_MFR(ID_MFR)
	) uut (.*);
	bsi_tester tst (.*);
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	initial begin
		reset_n = 1'b0;
		trst_n = 1'b1;
		{pinIn, coreOut, coreOutEn_n} = '0;
		void'($urandom(84));
		repeat (8) @(negedge ref_clk);
		reset_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		chk(32'(activeInstr), 32'(bsi_pkg::OP_IDENTIFICATION_WORD));
		tst.step(1'b0, 1'b0, q);
		tst.scan(1'b0, 32, $urandom, dout);
		chk(dout, {ID_REV, ID_DC, ID_DEV, ID_MFR, bsi_pkg::ID_MARK});
		// two passes over every code; update cells carry over between codes
		for (int i = 0; i < 16; i++) begin
			code = 3'(i);
			@(negedge ref_clk);
			pinIn = NPINS'($urandom);
			coreOut = NPINS'($urandom);
			coreOutEn_n = NPINS'($urandom);
			tst.scan(1'b1, 3, 32'(code), dout);
			chk(32'(dout[2:0]), 32'(bsi_pkg::IR_CAPTURE));
			chk(32'(activeInstr), 32'(code));
			din = $urandom;
			tst.scan(1'b0, 12, din, dout);
			if (code == bsi_pkg::OP_EXTEST || code == bsi_pkg::OP_SAMPLE) begin
				chk(32'(dout[11:8]), 32'(din[3:0]));
				// data cell nearest tdo captures the pad, then the enable cell
				for (int j = 0; j < NPINS; j++)
					cap[2*j +: 2] = {coreOutEn_n[j], pinIn[j]};
				chk(32'(dout[2*NPINS-1:0]), 32'(cap));
				upd = din[11:4];
			end else if (code == bsi_pkg::OP_IDENTIFICATION_WORD)
				chk(32'(dout[11:0]), 32'({ID_MFR, bsi_pkg::ID_MARK}));
			else
				chk(32'(dout[11:0]), 32'({din[10:0], 1'b0}));
			hz = (code == bsi_pkg::OP_HIGHZ);
			for (int j = 0; j < NPINS; j++) begin
				ep[j] = upd[2*j] & ~hz;
				ee[j] = upd[2*j+1] | hz;
			end
			if (code != bsi_pkg::OP_EXTEST && code != bsi_pkg::OP_CLAMP && !hz) begin
				ep = coreOut;
				ee = coreOutEn_n;
			end
			dout = 32'({coreReset_n, pinOutEn_n, pinOut & ~{NPINS{hz}}});
			chk(dout, 32'({code != bsi_pkg::OP_CLAMP, ee, ep}));
		end
		trst_n = 1'b0;
		repeat (8) @(negedge ref_clk);
		trst_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		chk(32'(activeInstr), 32'(bsi_pkg::OP_IDENTIFICATION_WORD));
		tst.step(1'b0, 1'b0, q);
		tst.scan(1'b0, 32, $urandom, dout);
		chk(dout, {ID_REV, ID_DC, ID_DEV, ID_MFR, bsi_pkg::ID_MARK});
		test_done();
	end
endmodule : bsi_tap_tb_top
`default_nettype wire

// File: bsi_tester.sv
// behavioural test controller on the scan port
`timescale 1ns/100ps
`default_nettype none
module bsi_tester (
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	initial {tck, tms, tdi} = 3'b010;
	// tck idles low; every edge lands on a ref_clk falling edge, tdo read late in the high phase
	task automatic step(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#40 tck = 1'b1;
		#30 q = tdo;
		#10 tck = 1'b0;
	endtask : step
	task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
		logic q;
		step(1'b1, 1'b0, q);
		if (ir)
			step(1'b1, 1'b0, q);
		repeat (2) step(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
	endtask : scan
endmodule : bsi_tester
`default_nettype wire
